// ==== verilog/dual_channel_watchdog_counter.v ====
// Two channel watchdog / interval timer top level
`timescale 1ns/1ns
`default_nettype none
`include "wdt_defines.vh"
module dual_channel_watchdog_counter (
    // Clock, reset and standby
    input  wire        clk_sys,
    input  wire        resetn,
    input  wire        hw_standby,
    // Subclock pin, slow and asynchronous
    input  wire        sub_clk_in,
    // Channel zero reset enable from the reset control register
    input  wire        reset_enable,
    // Word write ports, one per channel address
    input  wire        wr0_stb,
    input  wire        wr1_stb,
    input  wire [15:0] wr_data,
    // Control/status read strobes, used for the clear handshake
    input  wire        rd_cs0_stb,
    input  wire        rd_cs1_stb,
    // Read data
    output wire [7:0]  channel0_count,
    output wire [7:0]  channel0_control_status,
    output wire [7:0]  channel1_count,
    output wire [7:0]  channel1_control_status,
    // Overflow actions
    output wire        interval_overflow_interrupt0,
    output wire        interval_overflow_interrupt1,
    output wire        internal_reset_req,
    output wire        power_on_reset_req,
    output wire        nmi_req
);
    // ----------------------------------------------------------------
    // Main clock prescaler: free running, taps give divided pulses
    // ----------------------------------------------------------------
    reg  [`PRE_W-1:0]  main_clock_prescaler_ff;
    reg  [`PSUB_W-1:0] sub_div_ff;
    reg  [2:0]         sub_sync_ff;            // Three-stage synchroniser
    reg                sub_level_ff;           // Level agreed by stages 2, 3
    wire               sub_agree;
    wire               sub_rise;
    wire [7:0]         tick_main;
    wire [7:0]         tick_sub;

    // Pulse while the low n bits are all ones, just before they roll over to zero, one cycle wide
    function tap;
        input [`PRE_W-1:0] v;
        input [4:0]        n;
        integer            i;
        begin
            tap = 1'b1;
            for (i = 0; i < `PRE_W; i = i + 1) begin
                if (i < n && !v[i]) begin
                    tap = 1'b0;
                end
            end
        end
    endfunction

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            main_clock_prescaler_ff <= {`PRE_W{1'b0}};
        end else if (hw_standby) begin
            main_clock_prescaler_ff <= {`PRE_W{1'b0}};
        end else begin
            main_clock_prescaler_ff <= main_clock_prescaler_ff +
                                       {{(`PRE_W-1){1'b0}}, 1'b1};
        end
    end

    // Divide by 2,64,128,512,2048,8192,32768,131072
    assign tick_main[0] = tap(main_clock_prescaler_ff, 5'd1);
    assign tick_main[1] = tap(main_clock_prescaler_ff, 5'd6);
    assign tick_main[2] = tap(main_clock_prescaler_ff, 5'd7);
    assign tick_main[3] = tap(main_clock_prescaler_ff, 5'd9);
    assign tick_main[4] = tap(main_clock_prescaler_ff, 5'd11);
    assign tick_main[5] = tap(main_clock_prescaler_ff, 5'd13);
    assign tick_main[6] = tap(main_clock_prescaler_ff, 5'd15);
    assign tick_main[7] = tap(main_clock_prescaler_ff, 5'd17);

    // ----------------------------------------------------------------
    // Subclock prescaler, counted in the system domain
    // ----------------------------------------------------------------
    // Stages two and three must agree before an edge counts
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sub_sync_ff  <= 3'b000;
            sub_level_ff <= 1'b0;                       // Pin idles low
        end else begin
            sub_sync_ff <= {sub_sync_ff[1:0], sub_clk_in};
            // A level seen by one stage only never moves the agreed level
            if (sub_agree) begin
                sub_level_ff <= sub_sync_ff[2];
            end
        end
    end
    assign sub_agree = (sub_sync_ff[1] == sub_sync_ff[2]);
    // Rise of the agreed level, one system cycle wide
    assign sub_rise = sub_agree && sub_sync_ff[2] && !sub_level_ff;

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sub_div_ff <= {`PSUB_W{1'b0}};
        end else if (hw_standby) begin
            sub_div_ff <= {`PSUB_W{1'b0}};
        end else if (sub_rise) begin
            sub_div_ff <= sub_div_ff + {{(`PSUB_W-1){1'b0}}, 1'b1};
        end
    end

    // Subclock divide by 2..256, gated to one system cycle
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_sub
            assign tick_sub[g] = sub_rise && (&sub_div_ff[g:0]);
        end
    endgenerate

    // ----------------------------------------------------------------
    // Channels
    // ----------------------------------------------------------------
    wdt_channel #(.CH_ONE(0)) u_channel_zero (
        .clk_sys         (clk_sys),
        .resetn          (resetn),
        .hw_standby      (hw_standby),
        .tick_main       (tick_main),
        .tick_sub        (tick_sub),
        .wr_stb          (wr0_stb),
        .wr_data         (wr_data),
        .rd_cs_stb       (rd_cs0_stb),
        .reset_enable    (reset_enable),
        .count           (channel0_count),
        .control_status  (channel0_control_status),
        .interval_irq_ff (interval_overflow_interrupt0),
        .reset_req_ff    (internal_reset_req),
        .nmi_req_ff      ()
    );

    wdt_channel #(.CH_ONE(1)) u_channel_one (
        .clk_sys         (clk_sys),
        .resetn          (resetn),
        .hw_standby      (hw_standby),
        .tick_main       (tick_main),
        .tick_sub        (tick_sub),
        .wr_stb          (wr1_stb),
        .wr_data         (wr_data),
        .rd_cs_stb       (rd_cs1_stb),
        .reset_enable    (1'b0),
        .count           (channel1_count),
        .control_status  (channel1_control_status),
        .interval_irq_ff (interval_overflow_interrupt1),
        .reset_req_ff    (power_on_reset_req),
        .nmi_req_ff      (nmi_req)
    );
endmodule // dual_channel_watchdog_counter
`default_nettype wire

// ==== verilog/wdt_defines.vh ====
// Constants for the dual channel watchdog counter
`ifndef WDT_DEFINES_VH
`define WDT_DEFINES_VH
// ----------------------------------------------------------------
// Write password keys in the upper byte of a word write
// ----------------------------------------------------------------
`define KEY_COUNT      8'h5a
`define KEY_CTRL       8'ha5
// ----------------------------------------------------------------
// Control/status field positions
// ----------------------------------------------------------------
`define BIT_FLAG       7
`define BIT_MODE       6
`define BIT_RUN        5
`define BIT_SUBSEL     4
`define BIT_RSTNMI     3
`define CKS_HI         2
`define CKS_LO         0
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CS0_RESET      8'h18
`define CS1_RESET      8'h00
`define CS0_RSVD_MASK  8'h18
`define CNT_RESET      8'h00
`define CNT_MAX        8'hff
// ----------------------------------------------------------------
// Prescaler widths
// ----------------------------------------------------------------
`define PRE_W          17
`define PSUB_W         8
`endif

// ==== verilog/wdt_channel.v ====
// One watchdog channel: counter, control/status and overflow actions
`timescale 1ns/1ns
`default_nettype none
`include "wdt_defines.vh"
module wdt_channel #(
    parameter CH_ONE = 0                       // 1 selects channel one
) (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        resetn,
    input  wire        hw_standby,
    // Prescaler taps from the shared dividers
    input  wire [7:0]  tick_main,              // Pulses for codes 0..7
    input  wire [7:0]  tick_sub,               // Subclock pulses
    // Word write port and reads
    input  wire        wr_stb,
    input  wire [15:0] wr_data,
    input  wire        rd_cs_stb,              // Control/status read
    input  wire        reset_enable,           // Channel zero only
    output wire [7:0]  count,
    output wire [7:0]  control_status,
    // Overflow actions
    output reg         interval_irq_ff,
    output reg         reset_req_ff,
    output reg         nmi_req_ff
);
    reg  [7:0] cnt_ff;                         // Up-counter
    reg  [7:0] cs_ff;                          // Control/status
    reg        armed_ff;                       // Flag seen as 1 by a read
    wire [2:0] cks = cs_ff[`CKS_HI:`CKS_LO];
    wire       use_sub = (CH_ONE != 0) && cs_ff[`BIT_SUBSEL];
    wire       tick = use_sub ? tick_sub[cks] : tick_main[cks];
    wire       run = cs_ff[`BIT_RUN];
    wire       wdog = cs_ff[`BIT_MODE];
    wire       w_cnt = wr_stb && wr_data[15:8] == `KEY_COUNT;
    wire       w_cs = wr_stb && wr_data[15:8] == `KEY_CTRL;
    wire       ovf_ev = run && tick && !w_cnt && cnt_ff == `CNT_MAX;
    // Channel zero in watchdog mode, with or without reset enable: flag cleared by it
    wire       self_rst = wdog && (CH_ONE == 0);
    wire       int_rst = ovf_ev && self_rst && reset_enable;
    wire [7:0] rsvd_mask = `CS0_RSVD_MASK;     // Channel zero fixed bits
    // Low seven bits after a control write; fixed bits keep their ones
    wire [6:0] cs_wr_low = (CH_ONE != 0) ? wr_data[6:0] :
                           ((wr_data[6:0] & ~rsvd_mask[6:0]) |
                            (cs_ff[6:0] & rsvd_mask[6:0]));

    assign count = cnt_ff;
    // Reserved bits of channel zero read as one
    assign control_status = (CH_ONE != 0) ? cs_ff :
                            (cs_ff | `CS0_RSVD_MASK);

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cnt_ff <= `CNT_RESET;
        end else if (hw_standby || !run || (ovf_ev && self_rst)) begin
            cnt_ff <= `CNT_RESET;
        end else if (w_cnt) begin
            cnt_ff <= wr_data[7:0];                         // Write wins
        end else if (tick) begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // Control/status and overflow flag
    // ----------------------------------------------------------------
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cs_ff    <= (CH_ONE != 0) ? `CS1_RESET : `CS0_RESET;
            armed_ff <= 1'b0;
        end else if (hw_standby) begin
            cs_ff    <= (CH_ONE != 0) ? `CS1_RESET : `CS0_RESET;
            armed_ff <= 1'b0;
        end else if (ovf_ev && self_rst) begin
            // Channel reset; flag cleared automatically
            cs_ff    <= `CS0_RESET;
            armed_ff <= 1'b0;
        end else begin
            if (rd_cs_stb && cs_ff[`BIT_FLAG]) begin
                armed_ff <= 1'b1;
            end
            if (w_cs) begin
                cs_ff[6:0] <= cs_wr_low;
                // Only a 0 after a read clears; 1 is ignored
                if (!wr_data[`BIT_FLAG] && armed_ff) begin
                    cs_ff[`BIT_FLAG] <= 1'b0;
                    armed_ff         <= 1'b0;
                end
                // Channel one: stopping clears the flag
                if ((CH_ONE != 0) && !wr_data[`BIT_RUN]) begin
                    cs_ff[`BIT_FLAG] <= 1'b0;
                    armed_ff         <= 1'b0;
                end
            end
            // Set wins over any write clear in the same cycle
            if (ovf_ev) begin
                cs_ff[`BIT_FLAG] <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Overflow actions, one-cycle pulses
    // ----------------------------------------------------------------
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            interval_irq_ff <= 1'b0;
            reset_req_ff    <= 1'b0;
            nmi_req_ff      <= 1'b0;
        end else begin
            interval_irq_ff <= ovf_ev && !wdog;
            if (CH_ONE != 0) begin
                reset_req_ff <= ovf_ev && wdog && cs_ff[`BIT_RSTNMI];
                nmi_req_ff   <= ovf_ev && wdog && !cs_ff[`BIT_RSTNMI];
            end else begin
                reset_req_ff <= int_rst;
                nmi_req_ff   <= 1'b0;
            end
        end
    end
endmodule // wdt_channel
`default_nettype wire

// ==== dv/wdt_properties.sv ====
// Port-level assertion checker for the dual channel watchdog counter
`timescale 1ns/1ns
`default_nettype none
module wdt_props (
    // Clock, reset and stimulus
    input wire logic clk_sys, resetn, hw_standby, sub_clk_in,
    input wire logic reset_enable, wr0_stb, wr1_stb,
    input wire logic rd_cs0_stb, rd_cs1_stb,
    input wire logic [15:0] wr_data,
    // Register views
    input wire logic [7:0] channel0_count, channel0_control_status,
    input wire logic [7:0] channel1_count, channel1_control_status,
    // Overflow actions
    input wire logic interval_overflow_interrupt0,
    input wire logic interval_overflow_interrupt1,
    input wire logic internal_reset_req, power_on_reset_req, nmi_req
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    rsvd_bits_a: assert property (
        channel0_control_status[4:3] == 2'b11)
        else $error("reserved bits not one");
    cnt_step_a: assert property (
        channel1_control_status[5] && !wr1_stb
        && !hw_standby |=> channel1_count == $past(channel1_count)
        || channel1_count == $past(channel1_count) + 8'h01)
        else $error("counter stepped wrongly");
    cnt_halt_a: assert property (
        !channel0_control_status[5] && !wr0_stb
        |=> channel0_count == 8'h00) else $error("stopped counter not zero");
    // Flag is set in the pulse cycle and still set one later, so look one on
    irq_one_a: assert property (interval_overflow_interrupt1 |->
        !channel1_control_status[6] && channel1_count == 8'h00
        ##1 channel1_control_status[7]) else $error("bad interrupt one");
    irq_zero_a: assert property (interval_overflow_interrupt0 |->
        !channel0_control_status[6] ##1 channel0_control_status[7])
        else $error("bad interrupt zero");
    flag_rise_a: assert property ($rose(channel1_control_status[7])
        |-> channel1_count == 8'h00) else $error("flag set without wrap");
    por_sel_a: assert property (power_on_reset_req |->
        channel1_control_status[6] && channel1_control_status[3])
        else $error("power-on request wrong");
    nmi_sel_a: assert property (nmi_req |-> channel1_control_status[6]
        && !channel1_control_status[3]) else $error("nmi request wrong");
    int_rst_a: assert property (internal_reset_req |-> reset_enable
        ##[0:1] channel0_control_status == 8'h18)
        else $error("internal reset wrong");
    standby_a: assert property (hw_standby |=> channel1_count == 8'h00
        && channel0_control_status == 8'h18
        && channel1_control_status == 8'h00) else $error("standby missed");
endmodule // wdt_props
bind dual_channel_watchdog_counter wdt_props u_props (
    .clk_sys(clk_sys), .resetn(resetn), .hw_standby(hw_standby),
    .sub_clk_in(sub_clk_in), .reset_enable(reset_enable),
    .wr0_stb(wr0_stb), .wr1_stb(wr1_stb), .wr_data(wr_data),
    .rd_cs0_stb(rd_cs0_stb), .rd_cs1_stb(rd_cs1_stb),
    .channel0_count(channel0_count),
    .channel0_control_status(channel0_control_status),
    .channel1_count(channel1_count),
    .channel1_control_status(channel1_control_status),
    .interval_overflow_interrupt0(interval_overflow_interrupt0),
    .interval_overflow_interrupt1(interval_overflow_interrupt1),
    .internal_reset_req(internal_reset_req),
    .power_on_reset_req(power_on_reset_req), .nmi_req(nmi_req));
`default_nettype wire

// ==== dv/dual_channel_watchdog_counter_tb.sv ====
// Self-checking testbench for the dual channel watchdog counter
`timescale 1ns/1ns
`default_nettype none
module dual_channel_watchdog_counter_tb;
    // Stimulus, all given a value at time zero
    logic clk_sys = 0, resetn = 0, hw_standby = 0, reset_enable = 0;
    logic wr0_stb = 0, wr1_stb = 0, rd_cs0_stb = 0, rd_cs1_stb = 0;
    logic sub_clk_in = 0;
    logic [15:0] wr_data = 16'h0000;
    logic [7:0] cnt0, cs0, cnt1, cs1;
    logic irq0, irq1, irst, por, nmi;
    int err_count = 0, tests_run = 0;
    always #25 clk_sys = ~clk_sys;
    // Subclock pin is toggled slowly by the subclock scenario only
    dual_channel_watchdog_counter dut (.clk_sys(clk_sys), .resetn(resetn),
        .hw_standby(hw_standby), .sub_clk_in(sub_clk_in),
        .reset_enable(reset_enable), .wr0_stb(wr0_stb), .wr1_stb(wr1_stb),
        .wr_data(wr_data), .rd_cs0_stb(rd_cs0_stb), .rd_cs1_stb(rd_cs1_stb),
        .channel0_count(cnt0), .channel0_control_status(cs0),
        .channel1_count(cnt1), .channel1_control_status(cs1),
        .interval_overflow_interrupt0(irq0),
        .interval_overflow_interrupt1(irq1), .internal_reset_req(irst),
        .power_on_reset_req(por), .nmi_req(nmi));
    task automatic check(input string what, input logic [7:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One keyed word write; the register is settled on return
    task automatic wr(input bit ch, input logic [15:0] w);
        @(posedge clk_sys);
        wr_data <= w;
        if (ch) wr1_stb <= 1'b1; else wr0_stb <= 1'b1;
        @(posedge clk_sys);
        wr0_stb <= 1'b0;
        wr1_stb <= 1'b0;
        #1;
    endtask
    // Software read of a control/status, arming the flag clear
    task automatic rd(input bit ch);
        @(posedge clk_sys);
        if (ch) rd_cs1_stb <= 1'b1; else rd_cs0_stb <= 1'b1;
        @(posedge clk_sys);
        rd_cs0_stb <= 1'b0;
        rd_cs1_stb <= 1'b0;
    endtask
    function automatic logic act(input int k);
        case (k)
            0: return irq0;
            1: return irq1;
            2: return irst;
            3: return por;
            default: return nmi;
        endcase
    endfunction
    // Control first so the counter runs, then preload the top value
    task automatic ovf(input bit ch, input logic [7:0] c, input int k,
                       input logic exp);
        logic got;
        got = 1'b0;
        wr(ch, {8'ha5, c});
        wr(ch, 16'h5aff);
        repeat (12) begin
            @(posedge clk_sys);
            #1;
            if (act(k) === 1'b1) got = 1'b1;
        end
        check("action pulse", {7'h00, got}, {7'h00, exp});
    endtask
    task automatic t_access;
        check("cs0 reset", cs0, 8'h18);
        check("cs1 reset", cs1, 8'h00);
        wr(0, 16'h3320);
        check("bad key", cs0, 8'h18);
        wr(0, 16'ha520);
        check("cs0 run", cs0, 8'h38);
        wr(0, 16'h5a40);
        check("cnt0 load", cnt0, 8'h40);
        // Divide by two gives exactly ten ticks in twenty cycles
        repeat (20) @(posedge clk_sys);
        #1;
        check("cnt0 run", cnt0, 8'h4a);
        wr(0, 16'ha500);
        // The counter clears on the edge after the run bit reads 0
        @(posedge clk_sys);
        #1;
        check("cnt0 stop", cnt0, 8'h00);
        wr(1, 16'ha521);
        wr(1, 16'h5a00);
        repeat (128) @(posedge clk_sys);
        #1;
        check("div 64", cnt1, 8'h02);
    endtask
    task automatic t_interval;
        ovf(1, 8'h20, 1, 1'b1);
        check("flag set", cs1, 8'ha0);
        wr(1, 16'ha520);
        check("no read", cs1, 8'ha0);
        // Poll the flag as one twice before clearing it
        rd(1);
        #1;
        check("polled", {7'h00, cs1[7]}, 8'h01);
        rd(1);
        wr(1, 16'ha520);
        check("cleared", cs1[7], 8'h00);
        wr(1, 16'ha5a0);
        check("write one", cs1[7], 8'h00);
        ovf(1, 8'h20, 1, 1'b1);
        wr(1, 16'ha500);
        check("stop clears", cs1, 8'h00);
        ovf(0, 8'h20, 0, 1'b1);
        check("flag0", cs0[7], 8'h01);
    endtask
    task automatic t_watchdog;
        ovf(1, 8'h68, 3, 1'b1);
        wr(1, 16'ha500);
        ovf(1, 8'h60, 4, 1'b1);
        @(posedge clk_sys);
        reset_enable <= 1'b1;
        ovf(0, 8'h60, 2, 1'b1);
        check("self reset", cs0, 8'h18);
        @(posedge clk_sys);
        reset_enable <= 1'b0;
        ovf(0, 8'h60, 2, 1'b0);
        check("no reset", cs0, 8'h18);
    endtask
    task automatic t_standby;
        wr(1, 16'ha520);
        @(posedge clk_sys);
        hw_standby <= 1'b1;
        @(posedge clk_sys);
        @(posedge clk_sys);
        hw_standby <= 1'b0;
        #1;
        check("sb cs1", cs1, 8'h00);
        check("sb cnt1", cnt1, 8'h00);
    endtask
    // Eight subclock periods of eight system cycles, then let it settle
    task automatic sub_pulses;
        repeat (8) begin
            repeat (4) @(posedge clk_sys);
            sub_clk_in <= 1'b1;
            repeat (4) @(posedge clk_sys);
            sub_clk_in <= 1'b0;
        end
        repeat (8) @(posedge clk_sys);
        #1;
    endtask
    // Standby left the subclock divider at zero and channel one stopped;
    // main prescaler ticks keep coming and must not move the counter
    task automatic t_subclock;
        wr(1, 16'ha530);
        sub_pulses();
        check("sub div 2", cnt1, 8'h04);
        wr(1, 16'ha531);
        sub_pulses();
        check("sub div 4", cnt1, 8'h06);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Whole run is about 450 cycles; allow about nine times that
    initial begin
        #200000;
        err_count++;
        tally_and_finish();
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        #1;
        t_access();
        t_interval();
        t_watchdog();
        t_standby();
        t_subclock();
        tally_and_finish();
    end
endmodule // dual_channel_watchdog_counter_tb
`default_nettype wire
